//--- design/rtc_pkg.sv
// Shared constants and types for the serial real-time clock core
package rtc_pkg;

	// Register pointer values
	localparam logic [2:0] ADDR_SEC = 3'h0;
	localparam logic [2:0] ADDR_MIN = 3'h1;
	localparam logic [2:0] ADDR_HOUR = 3'h2;
	localparam logic [2:0] ADDR_DOW = 3'h3;
	localparam logic [2:0] ADDR_DATE = 3'h4;
	localparam logic [2:0] ADDR_MON = 3'h5;
	localparam logic [2:0] ADDR_YEAR = 3'h6;
	localparam logic [2:0] ADDR_CTRL = 3'h7;

	// Field positions
	localparam int BIT_FLAG = 7;
	localparam int BIT_CENT = 6;

	// Bus slave address, arbitrary value
	localparam logic [6:0] SLAVE_ADDR = 7'h68;

	// Power-on values of the flag bits
	localparam logic RST_OUT = 1'b1;
	localparam logic RST_FAIL = 1'b1;
	localparam logic RST_HALT = 1'b0;

	// BCD limits
	localparam logic [7:0] SEC_MAX = 8'h59;
	localparam logic [7:0] HOUR_MAX = 8'h23;
	localparam logic [7:0] DOW_MIN = 8'h01;
	localparam logic [7:0] DOW_MAX = 8'h07;
	localparam logic [7:0] DATE_MIN = 8'h01;
	localparam logic [7:0] MON_MIN = 8'h01;
	localparam logic [7:0] MON_MAX = 8'h12;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [7:0] BCD_ZERO = 8'h00;

	// Timing
	localparam int CRYSTAL_HZ = 32768;
	localparam int FREEZE_MS = 250;
	localparam int FREEZE_TICKS = CRYSTAL_HZ * FREEZE_MS / 1000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int OSC_TIMEOUT_US = 125;
	localparam int OSC_TIMEOUT_CYC = OSC_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

	// Calendar in BCD, one byte per field
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] dow;
		logic [7:0] date;
		logic [7:0] mon;
		logic [7:0] year;
	} time_t;

	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_WORD,
		ST_WDATA,
		ST_ACK,
		ST_TX,
		ST_MACK
	} bus_state_t;

endpackage : rtc_pkg

//--- design/rtc_core.sv
// Real-time clock core with two-wire register access and oscillator watch
`timescale 1ns/10ps
`default_nettype none

module rtc_core #(
	parameter int TICKS_PER_SEC = rtc_pkg::CRYSTAL_HZ,
	parameter int FREEZE_TICKS = rtc_pkg::FREEZE_TICKS,
	parameter int OSC_TIMEOUT_CYC = rtc_pkg::OSC_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Crystal time base
	input wire logic osc_i,
	// Two-wire bus
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Level output pin
	output logic out_o,
	output logic out_oe
);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers and glitch filter

	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;
	logic [2:0] osc_s_q;
	logic scl_f_q;
	logic sda_f_q;
	logic osc_f_q;
	logic scl_f_d;
	logic sda_f_d;
	logic osc_f_d;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			osc_s_q <= 3'h0;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
			osc_f_q <= 1'b0;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
			osc_s_q <= {osc_s_q[1:0], osc_i};
			scl_f_q <= scl_f_d;
			sda_f_q <= sda_f_d;
			osc_f_q <= osc_f_d;
		end
	end

	// A level counts only once the second and third stages agree
	assign scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
	assign sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
	assign osc_f_d = (osc_s_q[1] == osc_s_q[2]) ? osc_s_q[2] : osc_f_q;

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic osc_edge;

	assign scl_rise = scl_f_d & ~scl_f_q;
	assign scl_fall = ~scl_f_d & scl_f_q;
	assign bus_start = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
	assign bus_stop = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;
	assign osc_edge = osc_f_d & ~osc_f_q;

	////////////////////////////////////////////////////////////////////////
	// Flags and state shared by the sections below

	rtc_pkg::time_t live_q;
	rtc_pkg::time_t live_d;
	rtc_pkg::time_t vis_q;
	logic halt_q;
	logic fail_q;
	logic out_q;
	logic cent_en_q;
	logic cent_q;
	logic cent_d;
	logic wr_en_q;
	logic [2:0] wr_addr_q;
	logic [7:0] wr_data_q;
	logic rd_clock_q;
	logic freeze_q;
	logic osc_dead;
	logic osc_tick;
	logic sec_pulse;

	////////////////////////////////////////////////////////////////////////
	// Register read view

	function automatic logic [7:0] rd_byte(input logic [2:0] a,
		input rtc_pkg::time_t v, input logic h, input logic f,
		input logic ce, input logic c, input logic o);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			rtc_pkg::ADDR_SEC: r = {h, v.sec[6:0]};
			rtc_pkg::ADDR_MIN: r = {f, v.min[6:0]};
			rtc_pkg::ADDR_HOUR: r = {ce, c, v.hour[5:0]};
			rtc_pkg::ADDR_DOW: r = {5'h00, v.dow[2:0]};
			rtc_pkg::ADDR_DATE: r = {2'h0, v.date[5:0]};
			rtc_pkg::ADDR_MON: r = {3'h0, v.mon[4:0]};
			rtc_pkg::ADDR_YEAR: r = v.year;
			default: r = {o, 7'h00};
		endcase
		return r;
	endfunction : rd_byte

	////////////////////////////////////////////////////////////////////////
	// Two-wire bus slave

	rtc_pkg::bus_state_t state_q;
	rtc_pkg::bus_state_t after_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic [2:0] ptr_q;
	logic read_q;
	logic mack_q;
	logic [7:0] tx_next;
	logic [7:0] tx_cur;
	logic [2:0] ptr_inc;

	localparam int BIT_MSB = rtc_pkg::BIT_FLAG;

	assign ptr_inc = ptr_q + 3'h1;
	assign tx_cur = rd_byte(ptr_q, vis_q, halt_q, fail_q, cent_en_q,
		cent_q, out_q);
	assign tx_next = rd_byte(ptr_inc, vis_q, halt_q, fail_q, cent_en_q,
		cent_q, out_q);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= rtc_pkg::ST_IDLE;
			after_q <= rtc_pkg::ST_IDLE;
			bit_cnt_q <= 4'h0;
			rx_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 3'h0;
			read_q <= 1'b0;
			mack_q <= 1'b0;
			sda_oe <= 1'b0;
			wr_en_q <= 1'b0;
			wr_addr_q <= 3'h0;
			wr_data_q <= 8'h00;
			rd_clock_q <= 1'b0;
		end else begin
			wr_en_q <= 1'b0;
			rd_clock_q <= 1'b0;
			if (bus_start) begin
				state_q <= rtc_pkg::ST_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				state_q <= rtc_pkg::ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state_q)
				rtc_pkg::ST_ADDR, rtc_pkg::ST_WORD, rtc_pkg::ST_WDATA: begin
					if (scl_rise && bit_cnt_q != 4'h8) begin
						rx_q <= {rx_q[6:0], sda_f_q};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == 4'h8) begin
						state_q <= rtc_pkg::ST_ACK;
						sda_oe <= 1'b1;
						after_q <= rtc_pkg::ST_WDATA;
						if (state_q == rtc_pkg::ST_ADDR) begin
							read_q <= rx_q[0];
							after_q <= rx_q[0] ? rtc_pkg::ST_TX
								: rtc_pkg::ST_WORD;
							if (rx_q[7:1] != rtc_pkg::SLAVE_ADDR) begin
								state_q <= rtc_pkg::ST_IDLE;
								sda_oe <= 1'b0;
							end
						end else if (state_q == rtc_pkg::ST_WORD) begin
							ptr_q <= rx_q[2:0];
						end else begin
							wr_en_q <= 1'b1;
							wr_addr_q <= ptr_q;
							wr_data_q <= rx_q;
							ptr_q <= ptr_inc;
						end
					end
				end
				rtc_pkg::ST_ACK: begin
					if (scl_fall) begin
						bit_cnt_q <= 4'h0;
						state_q <= after_q;
						sda_oe <= 1'b0;
						if (after_q == rtc_pkg::ST_TX) begin
							tx_q <= tx_cur;
							sda_oe <= ~tx_cur[BIT_MSB];
							rd_clock_q <= (ptr_q != rtc_pkg::ADDR_CTRL);
						end
					end
				end
				rtc_pkg::ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_q == 4'h7) begin
							sda_oe <= 1'b0;
							state_q <= rtc_pkg::ST_MACK;
						end else begin
							tx_q <= {tx_q[6:0], 1'b0};
							sda_oe <= ~tx_q[6];
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end
					end
				end
				rtc_pkg::ST_MACK: begin
					if (scl_rise) begin
						mack_q <= ~sda_f_q;
					end else if (scl_fall) begin
						if (mack_q) begin
							ptr_q <= ptr_inc;
							tx_q <= tx_next;
							sda_oe <= ~tx_next[BIT_MSB];
							bit_cnt_q <= 4'h0;
							state_q <= rtc_pkg::ST_TX;
							rd_clock_q <= (ptr_inc != rtc_pkg::ADDR_CTRL);
						end else begin
							state_q <= rtc_pkg::ST_IDLE;
						end
					end
				end
				default: state_q <= rtc_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// The wire is only ever pulled low
	assign sda_o = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Oscillator watch and one-second prescaler

	logic [15:0] dead_cnt_q;
	logic [15:0] presc_q;

	assign osc_tick = osc_edge & ~halt_q;
	assign osc_dead = dead_cnt_q >= 16'(OSC_TIMEOUT_CYC - 1);
	assign sec_pulse = osc_tick && presc_q == 16'(TICKS_PER_SEC - 1);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dead_cnt_q <= 16'h0000;
		end else if (osc_edge) begin
			dead_cnt_q <= 16'h0000;
		end else if (!osc_dead) begin
			dead_cnt_q <= dead_cnt_q + 16'h0001;
		end
	end

	// Writing seconds restarts the fraction so the new second is full
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			presc_q <= 16'h0000;
		end else if (wr_en_q && wr_addr_q == rtc_pkg::ADDR_SEC) begin
			presc_q <= 16'h0000;
		end else if (sec_pulse) begin
			presc_q <= 16'h0000;
		end else if (osc_tick) begin
			presc_q <= presc_q + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Calendar counters

	function automatic logic [8:0] bcd_inc(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [8:0] r;
		r = 9'h000;
		if (v >= hi) begin
			r = {1'b1, lo};
		end else if (v[3:0] == 4'h9) begin
			r = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction : bcd_inc

	function automatic logic [7:0] month_len(input logic [7:0] m,
		input logic [7:0] y);
		logic [7:0] r;
		logic [6:0] yb;
		yb = 7'(y[7:4]) * 7'h0A + 7'(y[3:0]);
		case (m)
			8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
			8'h02: r = (yb[1:0] == 2'h0) ? 8'h29 : 8'h28;
			default: r = 8'h31;
		endcase
		return r;
	endfunction : month_len

	always_comb begin
		logic [8:0] s;
		s = 9'h000;
		live_d = live_q;
		cent_d = cent_q;
		s = bcd_inc(live_q.sec, rtc_pkg::BCD_ZERO, rtc_pkg::SEC_MAX);
		live_d.sec = s[7:0];
		if (s[8]) begin
			s = bcd_inc(live_q.min, rtc_pkg::BCD_ZERO, rtc_pkg::SEC_MAX);
			live_d.min = s[7:0];
			if (s[8]) begin
				s = bcd_inc(live_q.hour, rtc_pkg::BCD_ZERO, rtc_pkg::HOUR_MAX);
				live_d.hour = s[7:0];
				if (s[8]) begin
					s = bcd_inc(live_q.dow, rtc_pkg::DOW_MIN, rtc_pkg::DOW_MAX);
					live_d.dow = s[7:0];
					s = bcd_inc(live_q.date, rtc_pkg::DATE_MIN,
						month_len(live_q.mon, live_q.year));
					live_d.date = s[7:0];
					if (s[8]) begin
						s = bcd_inc(live_q.mon, rtc_pkg::MON_MIN,
							rtc_pkg::MON_MAX);
						live_d.mon = s[7:0];
						if (s[8]) begin
							s = bcd_inc(live_q.year, rtc_pkg::BCD_ZERO,
								rtc_pkg::YEAR_MAX);
							live_d.year = s[7:0];
							if (s[8] && cent_en_q) begin
								cent_d = ~cent_q;
							end
						end
					end
				end
			end
		end
	end

	// Time fields carry no defined power-up value; zero is used here
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			live_q <= '0;
			cent_q <= 1'b0;
		end else if (wr_en_q) begin
			case (wr_addr_q)
				rtc_pkg::ADDR_SEC: live_q.sec <= {1'b0, wr_data_q[6:0]};
				rtc_pkg::ADDR_MIN: live_q.min <= {1'b0, wr_data_q[6:0]};
				rtc_pkg::ADDR_HOUR: begin
					live_q.hour <= {2'h0, wr_data_q[5:0]};
					cent_q <= wr_data_q[rtc_pkg::BIT_CENT];
				end
				rtc_pkg::ADDR_DOW: live_q.dow <= {5'h00, wr_data_q[2:0]};
				rtc_pkg::ADDR_DATE: live_q.date <= {2'h0, wr_data_q[5:0]};
				rtc_pkg::ADDR_MON: live_q.mon <= {3'h0, wr_data_q[4:0]};
				rtc_pkg::ADDR_YEAR: live_q.year <= wr_data_q;
				default: live_q <= live_q;
			endcase
		end else if (sec_pulse) begin
			live_q <= live_d;
			cent_q <= cent_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Visible copy held still while a clock register is being read

	logic [15:0] freeze_cnt_q;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			freeze_q <= 1'b0;
			freeze_cnt_q <= 16'h0000;
		end else if (bus_stop ||
			(osc_edge && freeze_cnt_q == 16'(FREEZE_TICKS - 1))) begin
			freeze_q <= 1'b0;
			freeze_cnt_q <= 16'h0000;
		end else if (rd_clock_q && !freeze_q) begin
			freeze_q <= 1'b1;
		end else if (freeze_q && osc_edge) begin
			freeze_cnt_q <= freeze_cnt_q + 16'h0001;
		end
	end

	// Internal time keeps running; only the bus view waits
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			vis_q <= '0;
		end else if (!freeze_q || wr_en_q) begin
			vis_q <= live_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control flags

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			halt_q <= rtc_pkg::RST_HALT;
			out_q <= rtc_pkg::RST_OUT;
			cent_en_q <= 1'b0;
		end else if (wr_en_q) begin
			case (wr_addr_q)
				rtc_pkg::ADDR_SEC: halt_q <= wr_data_q[rtc_pkg::BIT_FLAG];
				rtc_pkg::ADDR_HOUR: cent_en_q <= wr_data_q[rtc_pkg::BIT_FLAG];
				rtc_pkg::ADDR_CTRL: out_q <= wr_data_q[rtc_pkg::BIT_FLAG];
				default: out_q <= out_q;
			endcase
		end
	end

	// A stop seen in the clearing cycle still leaves the flag set
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fail_q <= rtc_pkg::RST_FAIL;
		end else if (halt_q || osc_dead) begin
			fail_q <= 1'b1;
		end else if (wr_en_q && wr_addr_q == rtc_pkg::ADDR_MIN &&
			!wr_data_q[rtc_pkg::BIT_FLAG]) begin
			fail_q <= 1'b0;
		end
	end

	// Open drain: enable pulls low, release lets the pull-up win
	assign out_o = 1'b0;
	assign out_oe = ~out_q;

endmodule : rtc_core

`default_nettype wire

//--- sim/rtc_core_properties.sv
// Port checks for the real-time clock core
`timescale 1ns/10ps
`default_nettype none

module rtc_core_properties (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Bus and level pins
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic out_o,
	input wire logic out_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	////////////////////////////////////////////////////////////
	chk_out_drain: assert property (out_o == 1'b0)
		else $error("level pin driven high");
	chk_sda_drain: assert property (sda_o == 1'b0)
		else $error("data line driven high");
	chk_reset_out: assert property ($rose(arst_n) |-> !out_oe)
		else $error("level pin low after power-up");
	// Only a bus write, acknowledged by the core, may move the pin
	chk_out_by_ack: assert property (
		!$stable(out_oe) |-> $past(sda_oe) || $past(sda_oe, 2))
		else $error("level pin moved without a write");
	chk_out_scl_low: assert property (!$stable(out_oe) |-> !scl_i)
		else $error("level pin moved while bus clock high");
	chk_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_i)
		else $error("data line pulled while bus clock high");
	chk_sda_hold_high: assert property (
		scl_i && $past(scl_i) |-> $stable(sda_oe))
		else $error("data line moved while bus clock high");
	chk_ack_bounded: assert property (
		$rose(sda_oe) |-> ##[1:1000] !sda_oe)
		else $error("data line held low too long");
endmodule : rtc_core_properties

bind rtc_core rtc_core_properties i_props (
	.clk_sys(clk_sys),
	.arst_n(arst_n),
	.scl_i(scl_i),
	.sda_o(sda_o),
	.sda_oe(sda_oe),
	.out_o(out_o),
	.out_oe(out_oe)
);

`default_nettype wire

//--- sim/rtc_bus_master.sv
// Two-wire bus master model that drives the core's bus pins
`timescale 1ns/10ps
`default_nettype none

module rtc_bus_master #(
	parameter int HALF = 10
) (
	// Clock
	input wire logic clk_sys,
	// Bus wires, data line only ever pulled low
	output logic scl,
	output logic sda_pull,
	input wire logic sda_line
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	////////////////////////////////////////////////////////////
	task automatic half();
		repeat (HALF) @(posedge clk_sys);
	endtask : half

	// Data moves only mid-low, so no false start or stop is seen
	task automatic bit_io(input logic b, output logic r);
		sda_pull <= ~b;
		half();
		scl <= 1'b1;
		half();
		r = sda_line;
		scl <= 1'b0;
		half();
	endtask : bit_io

	task automatic start();
		sda_pull <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda_pull <= 1'b1;
		half();
		scl <= 1'b0;
		half();
	endtask : start

	task automatic stop();
		sda_pull <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda_pull <= 1'b0;
		half();
	endtask : stop

	task automatic xfer(input logic [7:0] tx, input logic mack,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(mack, ack);
	endtask : xfer
endmodule : rtc_bus_master

`default_nettype wire

//--- sim/test_rtc_core.sv
// Self-checking bench for the real-time clock core
`timescale 1ns/10ps
`default_nettype none

module test_rtc_core;
	localparam int TPS = 64;
	localparam int SEC_CYC = TPS * 32;
	logic clk_sys;
	logic arst_n;
	logic osc_i;
	logic osc_run;
	logic scl;
	logic sda_pull;
	logic sda_oe;
	logic out_oe;
	wire logic sda_i;
	int n_fail;
	int compares;
	logic [7:0] rq[$];
	logic [7:0] r8;
	logic ack;
	logic [7:0] ctl_w[4] = '{8'h3F, 8'h80, 8'hBF, 8'h80};
	// Hour in, date, month, year; then expected hour, date, month, year
	logic [7:0] cal[3][8] = '{
		'{8'hE3, 8'h31, 8'h12, 8'h99, 8'h80, 8'h01, 8'h01, 8'h00},
		'{8'h63, 8'h31, 8'h12, 8'h99, 8'h40, 8'h01, 8'h01, 8'h00},
		'{8'h23, 8'h28, 8'h02, 8'h24, 8'h00, 8'h29, 8'h02, 8'h24}};

	// Pull-up on the data line
	assign sda_i = ~(sda_pull | sda_oe);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Crystal runs in its own phase and can be stopped
	initial begin
		osc_i = 1'b0;
		#1.3;
		forever #80 osc_i <= osc_run ? ~osc_i : 1'b0;
	end

	rtc_core #(.TICKS_PER_SEC(TPS), .FREEZE_TICKS(64),
		.OSC_TIMEOUT_CYC(200)) i_dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .osc_i(osc_i),
		.scl_i(scl), .sda_i(sda_i), .sda_o(), .sda_oe(sda_oe),
		.out_o(), .out_oe(out_oe));

	rtc_bus_master i_master (.clk_sys(clk_sys), .scl(scl),
		.sda_pull(sda_pull), .sda_line(sda_i));

	////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		if (n_fail == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict

	task automatic send(input logic [7:0] b);
		logic [7:0] r;
		logic a;
		i_master.xfer(b, 1'b1, r, a);
		check("ack", {7'h00, a}, 8'h00);
	endtask : send

	task automatic wr(input logic [2:0] ptr, input logic [7:0] d[$]);
		i_master.start();
		send({rtc_pkg::SLAVE_ADDR, 1'b0});
		send({5'h00, ptr});
		foreach (d[i]) send(d[i]);
		i_master.stop();
	endtask : wr

	task automatic rd(input logic [2:0] ptr, input int n, input bit setp);
		logic [7:0] r;
		logic a;
		rq.delete();
		i_master.start();
		if (setp) begin
			send({rtc_pkg::SLAVE_ADDR, 1'b0});
			send({5'h00, ptr});
			i_master.start();
		end
		send({rtc_pkg::SLAVE_ADDR, 1'b1});
		for (int i = 0; i < n; i++) begin
			i_master.xfer(8'hFF, i == n - 1, r, a);
			rq.push_back(r);
		end
		i_master.stop();
	endtask : rd

	task automatic fail_is(input logic [7:0] exp);
		rd(rtc_pkg::ADDR_MIN, 1, 1'b1);
		check("fail flag", rq[0] & 8'h80, exp);
	endtask : fail_is

	////////////////////////////////////////////////////////////
	initial begin
		arst_n = 1'b0;
		osc_run = 1'b1;
		n_fail = 0;
		compares = 0;
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (10) @(posedge clk_sys);
		check("level pin", {7'h00, out_oe}, 8'h00);
		rd(rtc_pkg::ADDR_SEC, 8, 1'b1);
		check("halt", rq[0] & 8'h80, 8'h00);
		check("fail flag", rq[1] & 8'h80, 8'h80);
		check("control", rq[7], 8'h80);
		rd(3'h0, 1, 1'b0);
		check("pointer", rq[0], 8'h80);
		i_master.start();
		i_master.xfer({rtc_pkg::SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, r8, ack);
		i_master.stop();
		check("foreign address", {7'h00, ack}, 8'h01);
		foreach (ctl_w[i]) begin
			wr(rtc_pkg::ADDR_CTRL, '{ctl_w[i]});
			repeat (4) @(posedge clk_sys);
			check("level pin", {7'h00, out_oe}, {7'h00, ~ctl_w[i][7]});
			rd(rtc_pkg::ADDR_CTRL, 1, 1'b1);
			check("control", rq[0], ctl_w[i] & 8'h80);
		end
		repeat (4 * SEC_CYC) @(posedge clk_sys);
		wr(rtc_pkg::ADDR_MIN, '{8'h00});
		fail_is(8'h00);
		wr(rtc_pkg::ADDR_SEC, '{8'h80});
		fail_is(8'h80);
		wr(rtc_pkg::ADDR_SEC, '{8'h00});
		repeat (4 * SEC_CYC) @(posedge clk_sys);
		wr(rtc_pkg::ADDR_MIN, '{8'h00});
		fail_is(8'h00);
		osc_run = 1'b0;
		repeat (400) @(posedge clk_sys);
		osc_run = 1'b1;
		fail_is(8'h80);
		repeat (SEC_CYC) @(posedge clk_sys);
		fail_is(8'h80);
		repeat (4 * SEC_CYC) @(posedge clk_sys);
		// Year-end and leap-day rollovers, two seconds after the write
		foreach (cal[k]) begin
			wr(rtc_pkg::ADDR_SEC, '{8'h58, 8'h59, cal[k][0], 8'h07,
				cal[k][1], cal[k][2], cal[k][3]});
			repeat (2000) @(posedge clk_sys);
			rd(rtc_pkg::ADDR_SEC, 7, 1'b1);
			check("seconds", rq[0], 8'h00);
			check("minutes", rq[1] & 8'h7F, 8'h00);
			check("hours", rq[2], cal[k][4]);
			check("weekday", rq[3], 8'h01);
			check("date", rq[4], cal[k][5]);
			check("month", rq[5], cal[k][6]);
			check("year", rq[6], cal[k][7]);
		end
		print_verdict();
	end

	initial begin
		repeat (90000) @(posedge clk_sys);
		n_fail++;
		print_verdict();
	end
endmodule : test_rtc_core

`default_nettype wire
